/* src/self_test_ctrl.sv */
// self-test controller top: power-up launch, command port, flags and interrupt
// Operation
// - the logic under test is split into 31 scan chains that all shift together.
// - one 31-bit LFSR feeds every scan chain in parallel with pseudo-random bits.
// - all chain outputs are compressed into a 31-bit multiple-input signature register.
// - the logic test and the transducer test may run at the same time.
// - a logic test run lasts about 30 ms.
// - the transducer test moves the switch network into a test arrangement driven by a test current.
// - a rotating angle is emulated by stepping the current polarity and the driven elements.
// - the measured angle during the emulated rotation decides pass or fail.
// - a transducer test run lasts about 30 ms.
// - the transducer test runs at power-up when its nonvolatile enable is 1.
// - the host starts a test by writing the matching command to the control register.
// - completion shows as the done flag set or the transducer running flag cleared.
// - a failed test sets the failure flag, which the host clears before a test.
// - with the command disable bit at 1, start commands are ignored.
// - the logic test runs at power-up only when its nonvolatile enable is set.
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
module self_test_ctrl
  import self_test_pkg::*;
#(
  parameter int unsigned LBIST_RUN_CYCLES = LBIST_CYCLES,
  parameter int unsigned STEP_CYCLES = TST_CYCLES / NUM_STEPS,
  parameter logic [SIG_W-1:0] EXPECTED_SIG = EXPECTED_SIGNATURE
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [DATA_W-1:0] rdata,
  output logic irq,
  input wire logic powerup_transducer_test_enable,
  input wire logic powerup_logic_test_enable,
  input wire logic test_command_disable,
  input wire logic [ANGLE_W-1:0] measured_angle,
  input wire logic angle_valid,
  output logic test_mode,
  output logic current_pol,
  output logic [ELEM_W-1:0] element_sel
);

  pu_state_t pu_state;
  logic pu_logic_en_reg;
  logic pu_trans_en_reg;
  logic start_logic_reg;
  logic start_trans_reg;
  logic special_done_flag;
  logic [ERR_W-1:0] err_reg;
  logic [INT_W-1:0] int_status_reg;
  logic [INT_W-1:0] int_mask_reg;
  logic [INT_W-1:0] int_status_next;
  logic [INT_W-1:0] int_mask_next;
  logic [DATA_W-1:0] read_mux;
  logic lb_running;
  logic lb_done;
  logic lb_fail;
  logic [SIG_W-1:0] lb_signature;
  logic transducer_test_running_flag;
  logic ts_done;
  logic ts_fail;
  logic cmd_ok;
  logic [CMD_W-1:0] cmd;
  logic wr_status;
  logic wr_error;
  logic wr_int_status;
  logic wr_int_mask;
  logic any_start;
  logic done_set;

  ////////////////////////////////////////////////////////////////////////////
  // test engines
  lbist_engine #(
    .RUN_CYCLES(LBIST_RUN_CYCLES),
    .EXPECTED_SIG(EXPECTED_SIG)
  ) u_lbist (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .start(start_logic_reg),
    .running(lb_running),
    .done(lb_done),
    .fail(lb_fail),
    .signature(lb_signature)
  );

  transducer_seq #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_transducer (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .start(start_trans_reg),
    .measured_angle(measured_angle),
    .angle_valid(angle_valid),
    .running(transducer_test_running_flag),
    .done(ts_done),
    .fail(ts_fail),
    .test_mode(test_mode),
    .current_pol(current_pol),
    .element_sel(element_sel)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  assign cmd = wdata[CMD_W-1:0];
  assign wr_status = wr_stb && (addr == ADDR_STATUS);
  assign wr_error = wr_stb && (addr == ADDR_ERROR);
  assign wr_int_status = wr_stb && (addr == ADDR_INT_STATUS);
  assign wr_int_mask = wr_stb && (addr == ADDR_INT_MASK);
  // commands during the power-up launch are dropped, so the two sources never race
  assign cmd_ok = wr_stb && (addr == ADDR_CTRL) && !test_command_disable && (pu_state == PU_IDLE);
  assign any_start = start_logic_reg || start_trans_reg;
  assign done_set = (lb_done || ts_done) && !lb_running && !transducer_test_running_flag;

  ////////////////////////////////////////////////////////////////////////////
  // power-up launch; straps are caught one cycle after reset release
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pu_state <= PU_WAIT;
    end else if (ce) begin
      case (pu_state)
        PU_WAIT: pu_state <= PU_LAUNCH;
        PU_LAUNCH: pu_state <= PU_IDLE;
        PU_IDLE: pu_state <= PU_IDLE;
        default: pu_state <= PU_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pu_logic_en_reg <= 1'b0;
      pu_trans_en_reg <= 1'b0;
    end else if (ce && pu_state == PU_WAIT) begin
      pu_logic_en_reg <= powerup_logic_test_enable;
      pu_trans_en_reg <= powerup_transducer_test_enable;
    end
  end

  // both starts may fire together: the engines are independent
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_logic_reg <= 1'b0;
      start_trans_reg <= 1'b0;
    end else if (ce) begin
      start_logic_reg <= (pu_state == PU_LAUNCH && pu_logic_en_reg)
        || (cmd_ok && (cmd == CMD_LOGIC || cmd == CMD_BOTH));
      start_trans_reg <= (pu_state == PU_LAUNCH && pu_trans_en_reg)
        || (cmd_ok && (cmd == CMD_TRANSDUCER || cmd == CMD_BOTH));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // completion and failure flags; a set always beats a same-cycle clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      special_done_flag <= 1'b0;
    end else if (ce) begin
      special_done_flag <= done_set
        || (special_done_flag && !(wr_status && wdata[ST_DONE_BIT]) && !any_start);
    end
  end

  // never cleared by a passing run, only by the host
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      err_reg <= '0;
    end else if (ce) begin
      err_reg <= {ts_fail, lb_fail, lb_fail || ts_fail}
        | (err_reg & ~(wr_error ? wdata[ERR_W-1:0] : {ERR_W{1'b0}}));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt: sticky events, write one to clear, masked onto one level
  always_comb begin
    int_status_next = {lb_fail || ts_fail, ts_done, lb_done}
      | (int_status_reg & ~(wr_int_status ? wdata[INT_W-1:0] : {INT_W{1'b0}}));
    int_mask_next = wr_int_mask ? wdata[INT_W-1:0] : int_mask_reg;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_status_reg <= '0;
      int_mask_reg <= INT_MASK_RESET;
      irq <= 1'b0;
    end else if (ce) begin
      int_status_reg <= int_status_next;
      int_mask_reg <= int_mask_next;
      irq <= |(int_status_next & int_mask_next);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: data stands only in the cycle after the strobe
  always_comb begin
    read_mux = '0;
    if (addr == ADDR_CTRL) begin
      read_mux = '0;
    end else if (addr == ADDR_STATUS) begin
      read_mux = {29'h0000_0000, lb_running, transducer_test_running_flag, special_done_flag};
    end else if (addr == ADDR_ERROR) begin
      read_mux = {29'h0000_0000, err_reg};
    end else if (addr == ADDR_INT_STATUS) begin
      read_mux = {29'h0000_0000, int_status_reg};
    end else if (addr == ADDR_INT_MASK) begin
      read_mux = {29'h0000_0000, int_mask_reg};
    end else if (addr == ADDR_SIGNATURE) begin
      read_mux = {1'b0, lb_signature};
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= '0;
    end else if (ce) begin
      rdata <= rd_stb ? read_mux : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_cmd_disabled;
    @(posedge clk) disable iff (sys_rst)
    (ce && wr_stb && addr == ADDR_CTRL && test_command_disable && pu_state == PU_IDLE)
      |=> !start_logic_reg && !start_trans_reg;
  endproperty
  a_cmd_disabled: assert property (p_cmd_disabled) else $error("start taken while disabled");

  property p_cmd_both;
    @(posedge clk) disable iff (sys_rst)
    (ce && cmd_ok && cmd == CMD_BOTH && !lb_running && !transducer_test_running_flag)
      |=> start_logic_reg && start_trans_reg ##1 (lb_running && transducer_test_running_flag) [*2];
  endproperty
  a_cmd_both: assert property (p_cmd_both) else $error("tests not running together");

  property p_powerup_logic;
    @(posedge clk) disable iff (sys_rst)
    (ce && pu_state == PU_LAUNCH) |=> (start_logic_reg == $past(pu_logic_en_reg));
  endproperty
  a_powerup_logic: assert property (p_powerup_logic) else $error("power-up logic test launch wrong");

  property p_powerup_trans;
    @(posedge clk) disable iff (sys_rst)
    (ce && pu_state == PU_LAUNCH) |=> (start_trans_reg == $past(pu_trans_en_reg));
  endproperty
  a_powerup_trans: assert property (p_powerup_trans) else $error("power-up transducer launch wrong");

  property p_fail_set;
    @(posedge clk) disable iff (sys_rst)
    (ce && (lb_fail || ts_fail)) |=> err_reg[ERR_FAIL_BIT];
  endproperty
  a_fail_set: assert property (p_fail_set) else $error("failure not flagged");

  property p_fail_sticky;
    @(posedge clk) disable iff (sys_rst)
    (err_reg[ERR_FAIL_BIT] && !(ce && wr_error && wdata[ERR_FAIL_BIT])) |=> err_reg[ERR_FAIL_BIT];
  endproperty
  a_fail_sticky: assert property (p_fail_sticky) else $error("failure flag dropped by itself");

  property p_done_flag;
    @(posedge clk) disable iff (sys_rst)
    (ce && done_set) |=> special_done_flag;
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("completion not flagged");

  property p_status_read;
    @(posedge clk) disable iff (sys_rst)
    (ce && rd_stb && addr == ADDR_STATUS) |=> (rdata[1] == $past(transducer_test_running_flag));
  endproperty
  a_status_read: assert property (p_status_read) else $error("running flag misreported");

  property p_irq_level;
    @(posedge clk) disable iff (sys_rst)
    1'b1 |-> (irq == |(int_status_reg & int_mask_reg));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level disagrees with status");

endmodule : self_test_ctrl

/* src/self_test_pkg.sv */
// constants, register map and state types shared by the self-test controller
package self_test_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned NS_PER_MS = 1000000;
  localparam int unsigned LBIST_TIME_MS = 30;
  localparam int unsigned TST_TIME_MS = 30;
  localparam int unsigned LBIST_CYCLES = LBIST_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned TST_CYCLES = TST_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // logic self-test structure
  localparam int NUM_CHAINS = 31;
  localparam int SIG_W = 31;
  localparam int CHAIN_LEN = 8;
  localparam int LFSR_TAP_A = 30;
  localparam int LFSR_TAP_B = 27;
  localparam logic [SIG_W-1:0] LFSR_SEED = 31'h1234_5678;
  localparam logic [SIG_W-1:0] MISR_SEED = 31'h0000_0000;
  localparam logic [SIG_W-1:0] EXPECTED_SIGNATURE = 31'h2B3C_4D5E;

  ////////////////////////////////////////////////////////////////////////////
  // transducer self-test structure
  localparam int NUM_STEPS = 16;
  localparam int STEP_W = 4;
  localparam int ELEM_W = 3;
  localparam int ANGLE_W = 12;
  localparam logic [STEP_W-1:0] LAST_STEP = 4'hF;
  localparam logic [ANGLE_W-1:0] ANGLE_STEP = 12'h100;
  localparam logic [ANGLE_W-1:0] ANGLE_TOL = 12'h040;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_ERROR = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_INT_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_INT_MASK = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_SIGNATURE = 8'h14;
  localparam int CMD_W = 4;
  localparam logic [CMD_W-1:0] CMD_TRANSDUCER = 4'h1;
  localparam logic [CMD_W-1:0] CMD_LOGIC = 4'h2;
  localparam logic [CMD_W-1:0] CMD_BOTH = 4'h3;
  localparam int ST_DONE_BIT = 0;
  localparam int ERR_W = 3;
  localparam int ERR_FAIL_BIT = 0;
  localparam int INT_W = 3;
  localparam logic [INT_W-1:0] INT_MASK_RESET = 3'h0;

  typedef enum logic [2:0] {PU_WAIT = 3'b001, PU_LAUNCH = 3'b010, PU_IDLE = 3'b100} pu_state_t;
  typedef enum logic [1:0] {SEQ_IDLE = 2'b01, SEQ_RUN = 2'b10} seq_state_t;

endpackage : self_test_pkg

/* src/lbist_engine.sv */
// logic self-test engine: pattern generator, scan chains and signature register
`timescale 1ns/1ns
module lbist_engine
  import self_test_pkg::*;
#(
  parameter int unsigned RUN_CYCLES = LBIST_CYCLES,
  parameter logic [SIG_W-1:0] EXPECTED_SIG = EXPECTED_SIGNATURE
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic start,
  output logic running,
  output logic done,
  output logic fail,
  output logic [SIG_W-1:0] signature
);

  seq_state_t state_reg;
  logic [31:0] count_reg;
  logic [SIG_W-1:0] lfsr_reg;
  logic [SIG_W-1:0] misr_reg;
  logic [SIG_W-1:0] misr_next;
  logic [NUM_CHAINS-1:0] scan_out;
  logic last;

  assign running = (state_reg == SEQ_RUN);
  assign last = running && (count_reg == 32'(RUN_CYCLES - 1));
  assign signature = misr_reg;
  assign misr_next = {misr_reg[SIG_W-2:0], misr_reg[LFSR_TAP_A] ^ misr_reg[LFSR_TAP_B]} ^ scan_out;

  ////////////////////////////////////////////////////////////////////////////
  // all chains shift together, each fed by its own generator bit
  for (genvar g = 0; g < NUM_CHAINS; g++) begin : g_chain
    logic [CHAIN_LEN-1:0] chain_reg;
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        chain_reg <= '0;
      end else if (ce && start && !running) begin
        chain_reg <= '0;
      end else if (ce && running) begin
        chain_reg <= {chain_reg[CHAIN_LEN-2:0], lfsr_reg[g]};
      end
    end
    assign scan_out[g] = chain_reg[CHAIN_LEN-1];
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= SEQ_IDLE;
      count_reg <= '0;
    end else if (ce) begin
      case (state_reg)
        SEQ_IDLE: begin
          if (start) begin
            state_reg <= SEQ_RUN;
            count_reg <= '0;
          end
        end
        SEQ_RUN: begin
          count_reg <= count_reg + 32'h1;
          if (last) begin
            state_reg <= SEQ_IDLE;
          end
        end
        default: state_reg <= SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lfsr_reg <= LFSR_SEED;
      misr_reg <= MISR_SEED;
    end else if (ce && start && !running) begin
      lfsr_reg <= LFSR_SEED;
      misr_reg <= MISR_SEED;
    end else if (ce && running) begin
      lfsr_reg <= {lfsr_reg[SIG_W-2:0], lfsr_reg[LFSR_TAP_A] ^ lfsr_reg[LFSR_TAP_B]};
      misr_reg <= misr_next;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      done <= 1'b0;
      fail <= 1'b0;
    end else if (ce) begin
      done <= last;
      fail <= last && (misr_next != EXPECTED_SIG);
    end
  end

  property p_seed_load;
    @(posedge clk) disable iff (sys_rst)
    (ce && start && !running) |=> (lfsr_reg == LFSR_SEED) && (misr_reg == MISR_SEED) && running;
  endproperty
  a_seed_load: assert property (p_seed_load) else $error("seeds not loaded at start");

  property p_run_bound;
    @(posedge clk) disable iff (sys_rst)
    running |-> (count_reg < 32'(RUN_CYCLES));
  endproperty
  a_run_bound: assert property (p_run_bound) else $error("logic test overran its length");

endmodule : lbist_engine

/* src/transducer_seq.sv */
// transducer self-test sequencer: emulated rotation and angle check
`timescale 1ns/1ns
module transducer_seq
  import self_test_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = TST_CYCLES / NUM_STEPS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic start,
  input wire logic [ANGLE_W-1:0] measured_angle,
  input wire logic angle_valid,
  output logic running,
  output logic done,
  output logic fail,
  output logic test_mode,
  output logic current_pol,
  output logic [ELEM_W-1:0] element_sel
);

  seq_state_t state_reg;
  logic [STEP_W-1:0] step_reg;
  logic [31:0] count_reg;
  logic seen_reg;
  logic ok_reg;
  logic bad_reg;
  logic step_end;
  logic bad_next;
  logic [ANGLE_W-1:0] diff;

  assign running = (state_reg == SEQ_RUN);
  assign step_end = running && (count_reg == 32'(STEP_CYCLES - 1));
  // wrapped difference, so the check works across the 0/360 seam
  assign diff = measured_angle - (ANGLE_W'(step_reg) * ANGLE_STEP);
  assign bad_next = bad_reg || !seen_reg || !ok_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= SEQ_IDLE;
      step_reg <= '0;
      count_reg <= '0;
      test_mode <= 1'b0;
      current_pol <= 1'b0;
      element_sel <= '0;
    end else if (ce) begin
      case (state_reg)
        SEQ_IDLE: begin
          if (start) begin
            state_reg <= SEQ_RUN;
            step_reg <= '0;
            count_reg <= '0;
            test_mode <= 1'b1;
            current_pol <= 1'b0;
            element_sel <= '0;
          end
        end
        SEQ_RUN: begin
          count_reg <= step_end ? 32'h0 : count_reg + 32'h1;
          if (step_end && step_reg == LAST_STEP) begin
            state_reg <= SEQ_IDLE;
            test_mode <= 1'b0;
          end else if (step_end) begin
            step_reg <= step_reg + 4'h1;
            current_pol <= step_reg[STEP_W-1] ^ (&step_reg[ELEM_W-1:0]);
            element_sel <= ELEM_W'(step_reg + 4'h1);
          end
        end
        default: state_reg <= SEQ_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // a step passes only if a sample arrived and the latest one was in tolerance
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      seen_reg <= 1'b0;
      ok_reg <= 1'b0;
      bad_reg <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
    end else if (ce) begin
      done <= step_end && step_reg == LAST_STEP;
      fail <= step_end && step_reg == LAST_STEP && bad_next;
      if (!running || step_end) begin
        seen_reg <= 1'b0;
        ok_reg <= 1'b0;
        bad_reg <= running ? bad_next : 1'b0;
      end else if (angle_valid) begin
        seen_reg <= 1'b1;
        ok_reg <= (diff <= ANGLE_TOL) || (diff >= (ANGLE_W'(0) - ANGLE_TOL));
      end
    end
  end

  property p_step_advance;
    @(posedge clk) disable iff (sys_rst)
    (ce && step_end && step_reg != LAST_STEP) |=> (step_reg == $past(step_reg) + 4'h1) && test_mode;
  endproperty
  a_step_advance: assert property (p_step_advance) else $error("rotation step did not advance");

  property p_enter_test;
    @(posedge clk) disable iff (sys_rst)
    (ce && start && !running) |=> test_mode && !current_pol && (element_sel == '0);
  endproperty
  a_enter_test: assert property (p_enter_test) else $error("switch network not in test arrangement");

endmodule : transducer_seq

/* sim/self_test_ctrl_tb.sv */
// self-checking testbench for the self-test controller
`timescale 1ns/1ns
module self_test_ctrl_tb;
  import self_test_pkg::*;
  logic clk;
  logic sys_rst;
  logic ce;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic wr_stb;
  logic rd_stb;
  logic [DATA_W-1:0] rdata;
  logic irq;
  logic pu_xdcr;
  logic pu_logic;
  logic cmd_dis;
  logic [ANGLE_W-1:0] measured_angle;
  logic angle_valid;
  logic test_mode;
  logic current_pol;
  logic [ELEM_W-1:0] element_sel;
  logic bad_angle;
  logic [7:0] seen_sel;
  logic seen_pol;
  logic [DATA_W-1:0] d;
  int errors;
  int compares;

  // small counts keep the run short; the poll bound and the 60 frozen cycles depend on them
  self_test_ctrl #(.LBIST_RUN_CYCLES(40), .STEP_CYCLES(8)) dut (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .irq(irq), .powerup_transducer_test_enable(pu_xdcr), .powerup_logic_test_enable(pu_logic),
    .test_command_disable(cmd_dis), .measured_angle(measured_angle), .angle_valid(angle_valid),
    .test_mode(test_mode), .current_pol(current_pol), .element_sel(element_sel));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // measurement path: answers the emulated step angle, offset when a fault is wanted
  always @(posedge clk) begin
    measured_angle <= {current_pol, element_sel, 8'h00} + (bad_angle ? 12'h200 : 12'h000);
    angle_valid <= test_mode;
    if (test_mode) begin
      seen_sel[element_sel] <= 1'b1;
      if (current_pol) seen_pol <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 v = rdata;
  endtask : rd

  // polls until both engines report idle, bounded; running out of polls is a mismatch
  task automatic wait_idle();
    logic idle;
    idle = 1'b0;
    for (int i = 0; i < 200 && !idle; i++) begin
      rd(ADDR_STATUS, d);
      idle = (d[2:1] === 2'b00);
    end
    chk({31'h0, idle}, 32'h0000_0001);
    repeat (3) @(posedge clk);
  endtask : wait_idle

  task automatic run_xdcr(input logic bad);
    bad_angle = bad;
    seen_sel = 8'h00;
    seen_pol = 1'b0;
    wr(ADDR_CTRL, {28'h0, CMD_TRANSDUCER});
    rd(ADDR_STATUS, d);
    chk(d, 32'h0000_0002);
    #1 chk({31'h0, test_mode}, 32'h0000_0001);
    wait_idle();
    rd(ADDR_STATUS, d);
    chk(d, 32'h0000_0001);
    chk({23'h0, seen_pol, seen_sel}, 32'h0000_01FF);
    chk({31'h0, test_mode}, 32'h0000_0000);
  endtask : run_xdcr

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_powerup();
    rd(ADDR_STATUS, d);
    chk(d & 32'h6, 32'h0000_0004);
    wait_idle();
    rd(ADDR_STATUS, d);
    chk(d, 32'h0000_0001);
    rd(ADDR_ERROR, d);
    chk(d, 32'h0000_0003);
    rd(ADDR_INT_STATUS, d);
    chk(d, 32'h0000_0005);
    wr(ADDR_ERROR, 32'h0000_0007);
    rd(ADDR_ERROR, d);
    chk(d, 32'h0000_0000);
  endtask : t_powerup

  task automatic t_xdcr_irq();
    wr(ADDR_INT_MASK, 32'h0000_0002);
    wr(ADDR_INT_STATUS, 32'h0000_0007);
    rd(ADDR_INT_MASK, d);
    chk(d, 32'h0000_0002);
    chk({31'h0, irq}, 32'h0000_0000);
    run_xdcr(1'b0);
    rd(ADDR_ERROR, d);
    chk(d, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(ADDR_INT_STATUS, 32'h0000_0002);
    rd(ADDR_INT_STATUS, d);
    chk(d, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
  endtask : t_xdcr_irq

  // a failing run then a passing one: the failure must survive the pass
  task automatic t_fail_sticky();
    run_xdcr(1'b1);
    rd(ADDR_ERROR, d);
    chk(d, 32'h0000_0005);
    run_xdcr(1'b0);
    rd(ADDR_ERROR, d);
    chk(d, 32'h0000_0005);
    wr(ADDR_ERROR, 32'h0000_0007);
  endtask : t_fail_sticky

  task automatic t_disable_both();
    cmd_dis <= 1'b1;
    wr(ADDR_CTRL, {28'h0, CMD_BOTH});
    rd(ADDR_STATUS, d);
    chk(d & 32'h6, 32'h0000_0000);
    @(posedge clk);
    cmd_dis <= 1'b0;
    wr(ADDR_CTRL, {28'h0, CMD_BOTH});
    rd(ADDR_STATUS, d);
    chk(d, 32'h0000_0006);
    wait_idle();
    wr(ADDR_CTRL, {28'h0, CMD_LOGIC});
    rd(ADDR_STATUS, d);
    chk(d, 32'h0000_0004);
    // clock enable low must freeze the run: 60 frozen cycles outlast its 40
    @(posedge clk);
    ce <= 1'b0;
    repeat (60) @(posedge clk);
    ce <= 1'b1;
    rd(ADDR_STATUS, d);
    chk(d, 32'h0000_0004);
    wait_idle();
    rd(ADDR_CTRL, d);
    chk(d, 32'h0000_0000);
    rd(8'h40, d);
    chk(d, 32'h0000_0000);
  endtask : t_disable_both

  // second reset with only the transducer strap set
  task automatic t_powerup_xdcr();
    @(posedge clk);
    sys_rst <= 1'b1;
    pu_xdcr <= 1'b1;
    pu_logic <= 1'b0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    rd(ADDR_STATUS, d);
    chk(d, 32'h0000_0002);
    wait_idle();
    rd(ADDR_ERROR, d);
    chk(d, 32'h0000_0000);
  endtask : t_powerup_xdcr

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    summarize();
  end

  initial begin
    errors = 0;
    compares = 0;
    sys_rst = 1'b1;
    ce = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    pu_xdcr = 1'b0;
    pu_logic = 1'b1;
    cmd_dis = 1'b0;
    bad_angle = 1'b0;
    seen_sel = 8'h00;
    seen_pol = 1'b0;
    measured_angle = 12'h000;
    angle_valid = 1'b0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    #1 chk({rdata[25:0], irq, test_mode, current_pol, element_sel}, 32'h0000_0000);
    repeat (3) @(posedge clk);
    t_powerup();
    t_xdcr_irq();
    t_fail_sticky();
    t_disable_both();
    t_powerup_xdcr();
    summarize();
  end
endmodule : self_test_ctrl_tb
